// ==== common/gitd_defines.svh ====
/*
  constants of the graphic io transfer decoder: instruction field
  positions, codes, flag indices, coordinate sizes and reset values.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef GITD_DEFINES_SVH
`define GITD_DEFINES_SVH

// ----------------------------------------------------------------
// instruction word fields (word bit n of the host sits at [17-n])
// ----------------------------------------------------------------
`define GITD_OPC_HI        17
`define GITD_OPC_LO        12
`define GITD_DEV_HI        11
`define GITD_DEV_LO        6
`define GITD_SUB_HI        5
`define GITD_SUB_LO        4
`define GITD_CLR_BIT       3
`define GITD_IOP_BIT15     2
`define GITD_IOP_BIT16     1
`define GITD_IOP_BIT17     0

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define GITD_OPCODE        6'h38
`define GITD_DEV_A         6'h18
`define GITD_DEV_B         6'h1b
`define GITD_RS1_CODE      18'h38602
`define GITD_RS1_CLR_CODE  18'h3860a
`define GITD_SUB_0         2'h0
`define GITD_SUB_1         2'h1
`define GITD_SUB_2         2'h2
`define GITD_SUB_3         2'h3

// ----------------------------------------------------------------
// event flags
// ----------------------------------------------------------------
`define GITD_NFLAGS        7
`define GITD_FLG_STOP      0
`define GITD_FLG_PEN       1
`define GITD_FLG_EDGE      2
`define GITD_FLG_BUTTON    3
`define GITD_FLG_KEY       4
`define GITD_FLG_XOVF      5
`define GITD_FLG_YOVF      6

// ----------------------------------------------------------------
// coordinates and status word layout
// ----------------------------------------------------------------
`define GITD_DATA_W        10
`define GITD_POS_W         12
`define GITD_BASIC_RANGE   13'h0400
`define GITD_RS1_PA_HI     12
`define GITD_RS1_PA_LO     11
`define GITD_POS_OVF_BIT   12
`define GITD_PAPER_RST     2'h0
`define GITD_RUN_RST       1'h0

`endif

// ==== common/gitd_pkg.sv ====
/*
  types shared by the graphic io transfer decoder modules.
  assumes gitd_defines.svh is on the include path.
*/
`include "gitd_defines.svh"

package gitd_pkg;

  typedef enum logic [1:0] {
    GITD_KIND_NONE,
    GITD_KIND_READ,
    GITD_KIND_SKIP,
    GITD_KIND_OPER
  } gitd_kind_t;

  typedef struct packed {
    logic       match;
    logic       dev_b;
    logic [1:0] sub;
    logic       clr;
  } gitd_decode_t;

  typedef struct packed {
    logic stop;
    logic light_pen;
    logic edge_hit;
    logic button;
    logic key;
  } gitd_events_t;

  typedef struct packed {
    logic                       point_x;
    logic                       point_y;
    logic                       vector;
    logic [2:0]                 dir;
    logic [`GITD_DATA_W-1:0]    data;
  } gitd_draw_t;

  typedef struct packed {
    logic [17:0] rs1;
    logic [17:0] rs2;
    logic [17:0] rs3;
    logic [17:0] pc;
  } gitd_status_t;

endpackage

// ==== hdl/gitd_flag.sv ====
/*
  one event flag flip-flop: set by a hardware event, cleared by a
  command; a set in the clearing cycle wins.
  assumes set and clear are synchronous one-cycle pulses.
*/
`timescale 1ns/1ns

module gitd_flag (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 1'h0;
    end else if (set) begin
      flag <= 1'h1;
    end else if (clear) begin
      flag <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_flag_set;
    @(posedge mclk) disable iff (sys_rst) set |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event lost by flag");

  property p_flag_holds;
    @(posedge mclk) disable iff (sys_rst) flag && !clear |=> flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

endmodule // gitd_flag

// ==== hdl/gitd_axis.sv ====
/*
  one axis position register: absolute loads for points, signed
  relative steps for vectors, range check against the paper size.
  assumes load and step pulses never coincide.
*/
`timescale 1ns/1ns
`include "gitd_defines.svh"

module gitd_axis
  import gitd_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    load_abs,
  input  wire logic                    step_rel,
  input  wire logic                    negative,
  input  wire logic [`GITD_DATA_W-1:0] delta,
  input  wire logic [1:0]              paper,
  output logic      [`GITD_POS_W-1:0]  pos,
  output logic                         overflow
);

  logic [12:0] range;
  logic [12:0] next_pos;

  // ----------------------------------------------------------------
  // range and next position
  // ----------------------------------------------------------------
  always_comb begin
    range = `GITD_BASIC_RANGE << paper;
    if (negative) begin
      next_pos = {1'h0, pos} - {3'h0, delta};
    end else begin
      next_pos = {1'h0, pos} + {3'h0, delta};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pos <= '0;
    end else if (load_abs) begin
      pos <= {2'h0, delta};
    end else if (step_rel) begin
      pos <= next_pos[`GITD_POS_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow <= 1'h0;
    end else begin
      overflow <= step_rel && (next_pos >= range);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_point_abs;
    @(posedge mclk) disable iff (sys_rst)
      load_abs |=> pos == {2'h0, $past(delta)};
  endproperty
  a_point_abs: assert property (p_point_abs) else $error("point not absolute");

  property p_vector_rel;
    @(posedge mclk) disable iff (sys_rst)
      step_rel && !negative |=> pos == $past(pos) + {2'h0, $past(delta)};
  endproperty
  a_vector_rel: assert property (p_vector_rel) else $error("vector not relative");

  property p_range_basic;
    @(posedge mclk) disable iff (sys_rst)
      step_rel && !negative && paper == 2'h0 && ({1'h0, pos} + {3'h0, delta}) >= 13'h0400
      |=> overflow;
  endproperty
  a_range_basic: assert property (p_range_basic) else $error("basic range missed");

  property p_range_big;
    @(posedge mclk) disable iff (sys_rst)
      step_rel && !negative && paper == 2'h2 && ({1'h0, pos} + {3'h0, delta}) < 13'h1000
      |=> !overflow;
  endproperty
  a_range_big: assert property (p_range_big) else $error("false overflow");

endmodule // gitd_axis

// ==== hdl/gitd_decoder.sv ====
/*
  io transfer decoder of the vector display processor: matches the
  host's transfer instructions, answers read, skip and operate pulses,
  keeps event flags, paper size and the x and y position registers.
  assumes the host holds io_instr stable while any pulse of the
  instruction is high, and each pulse lasts at least two clocks.
*/
// Summary of operation
// - a word is a transfer only when its top six bits hold 111 000.
// - the block answers device codes 011 000 and 011 011 and no other.
// - bits 12 and 13 pick a subdevice, giving more operations per code.
// - each pulse gives its own response, chosen by pulse and device code.
// - there are six reads, seven skips and four operate commands.
// - a skip asks the host to skip when the tested event has happened.
// - each tested event sets its own flag, which holds it.
// - a read drives a status word, program counter or x and y position onto the bus.
// - a basic coordinate or vector length is ten bits, 1024 positions.
// - a two-bit paper size scales the range to 1024, 2048 or 4096 for sizes 0 to 2; size 3 gives range 0.
// - points are absolute from the origin, vectors relative to the last position.
// - a basic vector has a direction code picking one of eight directions.
// - the first status read is 703002, or 703012 with accumulator clear.
`timescale 1ns/1ns
`include "gitd_defines.svh"

module gitd_decoder
  import gitd_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic [17:0]            io_instr,
  input  wire logic [2:0]             io_pulse_field,
  input  wire logic [17:0]            io_write_data,
  input  wire gitd_events_t           events,
  input  wire gitd_draw_t             draw,
  input  wire gitd_status_t           status_in,
  output logic                        io_skip_request,
  output logic                        io_read_valid,
  output logic [17:0]                 io_read_data,
  output logic                        display_run,
  output logic [1:0]                  paper_size,
  output logic [`GITD_NFLAGS-1:0]     flags,
  output logic [`GITD_POS_W-1:0]      x_pos,
  output logic [`GITD_POS_W-1:0]      y_pos
);

  gitd_decode_t              dec;
  logic [2:0]                pulse_q;
  logic [2:0]                pulse_rise;
  logic                      read_now;
  logic                      skip_now;
  logic                      oper_now;
  logic [17:0]               next_read_word;
  logic [17:0]               read_word;
  logic                      skip_sel;
  logic [`GITD_NFLAGS-1:0]   flag_set;
  logic                      clear_flags;
  logic                      x_step;
  logic                      y_step;
  logic                      x_neg;
  logic                      y_neg;
  logic                      x_ovf;
  logic                      y_ovf;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  always_comb begin
    dec.match = (io_instr[`GITD_OPC_HI:`GITD_OPC_LO] == `GITD_OPCODE) &&
                ((io_instr[`GITD_DEV_HI:`GITD_DEV_LO] == `GITD_DEV_A) ||
                 (io_instr[`GITD_DEV_HI:`GITD_DEV_LO] == `GITD_DEV_B));
    dec.dev_b = io_instr[`GITD_DEV_HI:`GITD_DEV_LO] == `GITD_DEV_B;
    dec.sub   = io_instr[`GITD_SUB_HI:`GITD_SUB_LO];
    dec.clr   = io_instr[`GITD_CLR_BIT];
  end

  // pulse positions: bit 15 operates, bit 16 reads, bit 17 skips
  always_comb begin
    read_now = dec.match && io_pulse_field[`GITD_IOP_BIT16] && (dec.sub != `GITD_SUB_3);
    skip_now = dec.match && io_pulse_field[`GITD_IOP_BIT17] &&
               (!dec.dev_b || dec.sub != `GITD_SUB_3);
    oper_now = dec.match && pulse_rise[`GITD_IOP_BIT15];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_q <= 3'h0;
    end else begin
      pulse_q <= io_pulse_field;
    end
  end

  assign pulse_rise = io_pulse_field & ~pulse_q;

  // ----------------------------------------------------------------
  // read operations
  // ----------------------------------------------------------------
  always_comb begin
    next_read_word = 18'h00000;
    case ({dec.dev_b, dec.sub})
      {1'h0, `GITD_SUB_0}: begin
        next_read_word = status_in.rs1;
        next_read_word[`GITD_RS1_PA_HI:`GITD_RS1_PA_LO] = paper_size;
      end
      {1'h0, `GITD_SUB_1}: next_read_word = status_in.rs2;
      {1'h0, `GITD_SUB_2}: next_read_word = status_in.pc;
      {1'h1, `GITD_SUB_0}: next_read_word = {5'h00, flags[`GITD_FLG_XOVF], x_pos};
      {1'h1, `GITD_SUB_1}: next_read_word = {5'h00, flags[`GITD_FLG_YOVF], y_pos};
      {1'h1, `GITD_SUB_2}: next_read_word = status_in.rs3;
      default: next_read_word = 18'h00000;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      read_word <= 18'h00000;
    end else if (read_now) begin
      read_word <= next_read_word;
    end else begin
      read_word <= 18'h00000;
    end
  end

  // data only shows while the read pulse is still high
  assign io_read_valid = read_now && pulse_q[`GITD_IOP_BIT16];
  assign io_read_data  = io_read_valid ? read_word : 18'h00000;

  // ----------------------------------------------------------------
  // skip operations
  // ----------------------------------------------------------------
  always_comb begin
    skip_sel = 1'h0;
    case ({dec.dev_b, dec.sub})
      {1'h0, `GITD_SUB_0}: skip_sel = flags[`GITD_FLG_STOP];
      {1'h0, `GITD_SUB_1}: skip_sel = flags[`GITD_FLG_PEN];
      {1'h0, `GITD_SUB_2}: skip_sel = flags[`GITD_FLG_EDGE];
      {1'h0, `GITD_SUB_3}: skip_sel = flags[`GITD_FLG_BUTTON];
      {1'h1, `GITD_SUB_0}: skip_sel = flags[`GITD_FLG_KEY];
      {1'h1, `GITD_SUB_1}: skip_sel = flags[`GITD_FLG_XOVF];
      {1'h1, `GITD_SUB_2}: skip_sel = flags[`GITD_FLG_YOVF];
      default: skip_sel = 1'h0;
    endcase
  end

  assign io_skip_request = skip_now && skip_sel;

  // ----------------------------------------------------------------
  // operate commands
  // ----------------------------------------------------------------
  assign clear_flags = oper_now && !dec.dev_b && dec.sub == `GITD_SUB_2;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      display_run <= `GITD_RUN_RST;
    end else if (oper_now && !dec.dev_b && dec.sub == `GITD_SUB_0) begin
      display_run <= 1'h1;
    end else if (oper_now && !dec.dev_b && dec.sub == `GITD_SUB_1) begin
      display_run <= 1'h0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      paper_size <= `GITD_PAPER_RST;
    end else if (oper_now && dec.dev_b && dec.sub == `GITD_SUB_0) begin
      paper_size <= io_write_data[1:0];
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  always_comb begin
    flag_set                    = '0;
    flag_set[`GITD_FLG_STOP]    = events.stop;
    flag_set[`GITD_FLG_PEN]     = events.light_pen;
    flag_set[`GITD_FLG_EDGE]    = events.edge_hit;
    flag_set[`GITD_FLG_BUTTON]  = events.button;
    flag_set[`GITD_FLG_KEY]     = events.key;
    flag_set[`GITD_FLG_XOVF]    = x_ovf;
    flag_set[`GITD_FLG_YOVF]    = y_ovf;
  end

  for (genvar i = 0; i < `GITD_NFLAGS; i++) begin : g_flag
    gitd_flag u_flag (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .set     (flag_set[i]),
      .clear   (clear_flags),
      .flag    (flags[i])
    );
  end

  // ----------------------------------------------------------------
  // position registers
  // ----------------------------------------------------------------
  // 0 +x, 1 +x+y, 2 +y, 3 -x+y, 4 -x, 5 -x-y, 6 -y, 7 +x-y
  always_comb begin
    x_step = 1'h0;
    y_step = 1'h0;
    x_neg  = 1'h0;
    y_neg  = 1'h0;
    case (draw.dir)
      3'h0: x_step = 1'h1;
      3'h1: begin
        x_step = 1'h1;
        y_step = 1'h1;
      end
      3'h2: y_step = 1'h1;
      3'h3: begin
        x_step = 1'h1;
        x_neg  = 1'h1;
        y_step = 1'h1;
      end
      3'h4: begin
        x_step = 1'h1;
        x_neg  = 1'h1;
      end
      3'h5: begin
        x_step = 1'h1;
        x_neg  = 1'h1;
        y_step = 1'h1;
        y_neg  = 1'h1;
      end
      3'h6: begin
        y_step = 1'h1;
        y_neg  = 1'h1;
      end
      3'h7: begin
        x_step = 1'h1;
        y_step = 1'h1;
        y_neg  = 1'h1;
      end
      default: x_step = 1'h0;
    endcase
  end

  gitd_axis u_x (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .load_abs (draw.point_x),
    .step_rel (draw.vector && x_step),
    .negative (x_neg),
    .delta    (draw.data),
    .paper    (paper_size),
    .pos      (x_pos),
    .overflow (x_ovf)
  );

  gitd_axis u_y (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .load_abs (draw.point_y),
    .step_rel (draw.vector && y_step),
    .negative (y_neg),
    .delta    (draw.data),
    .paper    (paper_size),
    .pos      (y_pos),
    .overflow (y_ovf)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_skip_in_pulse;
    @(posedge mclk) disable iff (sys_rst)
      !io_pulse_field[`GITD_IOP_BIT17] |-> !io_skip_request;
  endproperty
  a_skip_in_pulse: assert property (p_skip_in_pulse) else $error("skip outside pulse");

  property p_data_in_pulse;
    @(posedge mclk) disable iff (sys_rst)
      !io_pulse_field[`GITD_IOP_BIT16] |-> io_read_data == 18'h00000 && !io_read_valid;
  endproperty
  a_data_in_pulse: assert property (p_data_in_pulse) else $error("data outside pulse");

  property p_foreign_dev;
    @(posedge mclk) disable iff (sys_rst)
      io_instr[11:6] != 6'h18 && io_instr[11:6] != 6'h1b |->
      !io_skip_request && !io_read_valid;
  endproperty
  a_foreign_dev: assert property (p_foreign_dev) else $error("foreign code answered");

  property p_not_transfer;
    @(posedge mclk) disable iff (sys_rst)
      io_instr[17:12] != 6'h38 |-> !io_skip_request && !io_read_valid;
  endproperty
  a_not_transfer: assert property (p_not_transfer) else $error("non transfer answered");

  property p_skip_stop;
    @(posedge mclk) disable iff (sys_rst)
      io_instr == 18'h38601 && io_pulse_field == 3'h1 |->
      io_skip_request == flags[`GITD_FLG_STOP];
  endproperty
  a_skip_stop: assert property (p_skip_stop) else $error("stop skip wrong");

  property p_rs1_read;
    @(posedge mclk) disable iff (sys_rst)
      (io_instr == `GITD_RS1_CODE || io_instr == `GITD_RS1_CLR_CODE) &&
      io_pulse_field == 3'h2 ##1 io_pulse_field == 3'h2 && $stable(io_instr) |->
      io_read_valid && io_read_data[12:11] == paper_size;
  endproperty
  a_rs1_read: assert property (p_rs1_read) else $error("status one read wrong");

  property p_xpos_read;
    @(posedge mclk) disable iff (sys_rst)
      io_instr[17:4] == {`GITD_OPCODE, `GITD_DEV_B, `GITD_SUB_0} && io_pulse_field == 3'h2 ##1
      io_pulse_field == 3'h2 && $stable(io_instr) && $stable(x_pos) |->
      io_read_data[11:0] == x_pos;
  endproperty
  a_xpos_read: assert property (p_xpos_read) else $error("x position read wrong");

  property p_start;
    @(posedge mclk) disable iff (sys_rst)
      io_instr[17:4] == {`GITD_OPCODE, `GITD_DEV_A, `GITD_SUB_0} &&
      $rose(io_pulse_field[`GITD_IOP_BIT15]) |=> display_run;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");

  c_skip_taken: cover property (@(posedge mclk) disable iff (sys_rst) io_skip_request);
  c_read_given: cover property (@(posedge mclk) disable iff (sys_rst) io_read_valid);
  c_overflow:   cover property (@(posedge mclk) disable iff (sys_rst) x_ovf || y_ovf);
  c_big_paper:  cover property (@(posedge mclk) disable iff (sys_rst) paper_size == 2'h2);
  c_read_clear: cover property (@(posedge mclk) disable iff (sys_rst) io_read_valid && dec.clr);

endmodule // gitd_decoder

// ==== bench/gitd_host_model.sv ====
/*
  host processor model: issues transfer words, sends one serial pulse
  per set pulse bit, merges read data into its accumulator.
  assumes the bench calls exec just after a clock edge.
*/
`timescale 1ns/1ns

module gitd_host_model (
  input  wire logic        mclk,
  input  wire logic        io_skip_request,
  input  wire logic        io_read_valid,
  input  wire logic [17:0] io_read_data,
  output logic      [17:0] io_instr,
  output logic      [2:0]  io_pulse_field,
  output logic             res_strobe,
  output logic      [19:0] res_word
);
  localparam int PW = 3;
  logic [17:0] acc;
  logic        skip;
  logic        stray;

  initial begin
    io_instr       = 18'h0;
    io_pulse_field = 3'h0;
    res_strobe     = 1'b0;
    res_word       = 20'h0;
  end

  // ------------------------------------------------------------
  // one transfer word
  // ------------------------------------------------------------
  task automatic exec(input logic [17:0] w, input logic [17:0] ac_in);
    @(posedge mclk);
    #1;
    io_instr = w;
    skip     = 1'b0;
    stray    = 1'b0;
    acc      = w[3] ? 18'h0 : ac_in;
    for (int b = 0; b < 3; b++) begin
      if (w[b]) begin
        io_pulse_field = 3'(1 << b);
        repeat (PW) @(posedge mclk);
        if (b == 0) skip = io_skip_request;
        if (b == 1) acc = acc | io_read_data;
        #1 io_pulse_field = 3'h0;
        @(posedge mclk);
        stray = stray | io_skip_request | io_read_valid;
        #1;
      end
    end
    // released word lines show the inverse of the last value
    io_instr   = ~w;
    res_word   = {stray, skip, acc};
    res_strobe = 1'b1;
    @(posedge mclk);
    #1 res_strobe = 1'b0;
  endtask
endmodule // gitd_host_model

// ==== bench/gitd_decoder_tb.sv ====
/*
  self-checking bench of the transfer decoder with a host model.
  assumes gitd_pkg is compiled first.
*/
`timescale 1ns/1ns

module gitd_decoder_tb import gitd_pkg::*;;
  logic              mclk, sys_rst, io_skip_request, io_read_valid, display_run, res_strobe;
  logic [17:0]       io_instr, io_write_data, io_read_data, w;
  logic [2:0]        io_pulse_field;
  logic [1:0]        paper_size, pe;
  logic [6:0]        flags;
  logic [11:0]       x_pos, y_pos;
  logic [19:0]       res_word, exp_word;
  logic [19:0]       expq[$];
  gitd_events_t      events;
  gitd_draw_t        draw;
  gitd_status_t      status_in;
  int                mismatches, total_checks, cycles;

  gitd_decoder dut (.mclk(mclk), .sys_rst(sys_rst), .io_instr(io_instr),
    .io_pulse_field(io_pulse_field), .io_write_data(io_write_data), .events(events),
    .draw(draw), .status_in(status_in), .io_skip_request(io_skip_request),
    .io_read_valid(io_read_valid), .io_read_data(io_read_data), .display_run(display_run),
    .paper_size(paper_size), .flags(flags), .x_pos(x_pos), .y_pos(y_pos));
  gitd_host_model host (.mclk(mclk), .io_skip_request(io_skip_request),
    .io_read_valid(io_read_valid), .io_read_data(io_read_data), .io_instr(io_instr),
    .io_pulse_field(io_pulse_field), .res_strobe(res_strobe), .res_word(res_word));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [17:0] word(input logic [5:0] d, input logic [1:0] s,
                                       input logic c, input logic [2:0] p);
    return {6'h38, d, s, c, p};
  endfunction

  function automatic logic [17:0] sk(input int i);
    return word(i < 4 ? 6'h18 : 6'h1b, 2'(i < 4 ? i : i - 4), 1'b0, 3'h1);
  endfunction

  function automatic logic [17:0] rd_exp(input int j);
    case (j)
      0: return {status_in.rs1[17:13], pe, status_in.rs1[10:0]};
      1: return status_in.rs2;
      2: return status_in.pc;
      3: return {5'h0, 1'b1, 12'd1100};
      4: return {5'h0, 1'b1, 12'hffb};
      default: return status_in.rs3;
    endcase
  endfunction

  task automatic io_transfer_instruction(input logic [17:0] wd, input logic ex_skip, input logic [17:0] ex_data);
    logic [17:0] a;
    a = 18'($urandom);
    expq.push_back({1'b0, ex_skip, (wd[3] ? 18'h0 : a) | ex_data});
    host.exec(wd, a);
  endtask

  task automatic pulse_draw(input gitd_draw_t d);
    draw = d;
    @(posedge mclk);
    #1 draw = '0;
    @(posedge mclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // result watcher and timeout
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    if (res_strobe) begin
      exp_word = expq.pop_front();
      check(res_word, exp_word);
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    io_write_data = 18'h0;
    events = '0;
    draw = '0;
    pe = 2'h0;
    void'($urandom(67));
    status_in = {18'($urandom), 18'($urandom), 18'($urandom), 18'($urandom)};
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'b0;
    check(20'({display_run, paper_size, flags}), 20'h0);
    check({8'h0, x_pos | y_pos}, 20'h0);
    for (int i = 0; i < 7; i++) io_transfer_instruction(sk(i), 1'b0, 18'h0);
    for (int k = 0; k < 5; k++) begin
      events = gitd_events_t'(5'h10 >> k);
      @(posedge mclk);
      #1 events = '0;
    end
    pulse_draw({3'b100, 3'h0, 10'd1000});
    pulse_draw({3'b001, 3'h0, 10'd100});
    pulse_draw({3'b010, 3'h0, 10'd5});
    pulse_draw({3'b001, 3'h6, 10'd10});
    repeat (3) @(posedge mclk);
    #1 check(20'(flags), 20'h7f);
    for (int i = 0; i < 7; i++) io_transfer_instruction(sk(i), 1'b1, 18'h0);
    io_transfer_instruction(word(6'h19, 2'h0, 1'b0, 3'h1), 1'b0, 18'h0);
    io_transfer_instruction({6'h30, 6'h18, 6'h02}, 1'b0, 18'h0);
    io_transfer_instruction(word(6'h18, 2'h3, 1'b0, 3'h2), 1'b0, 18'h0);
    io_transfer_instruction(18'h38602, 1'b0, rd_exp(0));
    io_transfer_instruction(18'h3860a, 1'b0, rd_exp(0));
    for (int j = 0; j < 6; j++) begin
      w = word(j < 3 ? 6'h18 : 6'h1b, 2'(j % 3), 1'($urandom), 3'h2);
      io_transfer_instruction(w, 1'b0, rd_exp(j));
    end
    io_transfer_instruction(word(6'h18, 2'h0, 1'b0, 3'h7), 1'b1, rd_exp(0));
    check(20'(display_run), 20'h1);
    io_transfer_instruction(word(6'h18, 2'h1, 1'b0, 3'h4), 1'b0, 18'h0);
    check(20'(display_run), 20'h0);
    io_write_data = {16'($urandom), 2'h2};
    pe = io_write_data[1:0];
    io_transfer_instruction(word(6'h1b, 2'h0, 1'b0, 3'h4), 1'b0, 18'h0);
    check(20'(paper_size), 20'(pe));
    io_transfer_instruction(18'h38602, 1'b0, rd_exp(0));
    io_transfer_instruction(word(6'h18, 2'h2, 1'b0, 3'h4), 1'b0, 18'h0);
    pulse_draw({3'b001, 3'h0, 10'd1000});
    check(20'(x_pos), 20'd2100);
    check(20'(flags), 20'h0);
    io_transfer_instruction(sk(0), 1'b0, 18'h0);
    repeat (2) @(posedge mclk);
    check(20'(expq.size()), 20'h0);
    report_and_stop();
  end
endmodule // gitd_decoder_tb
